// ===== src/icf_top.sv
// I2C control-flag logic: control register, START/STOP sequencing, event flag and pin routing
// Operation
// - Begin request with the bus free drives a START condition.
// - Begin request with the bus busy waits for STOP, then drives START.
// - Begin request as master after a byte gives a repeated START.
// - Begin request is writable anytime and only software clears it.
// - Terminate request as master transmits a STOP condition.
// - Hardware clears the terminate request once a STOP is seen on the bus.
// - Terminate request in bus error state recovers without sending STOP.
// - Begin and terminate together as master give STOP then START.
// - Every non-idle status entry sets the serial event flag.
// - Software or error recovery clears the event flag; clock held low while set, except in bus error state.
// - After the event flag clears, the next START, STOP or byte follows.
// - Acknowledge enable drives ACK in the acknowledge slot of a received byte; clear gives NACK.
// - Idle status code means no information and the event flag stays zero.
// - Pin swap select exchanges the clock and data pin pair at once.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module icf_top #(
  parameter int unsigned HALF_CYC = icf_pkg::SCL_HALF_CYC,
  parameter int unsigned HOLD_CYC = icf_pkg::DATA_HOLD_CYC
) (
  // Clock, reset, enable
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // Register port
  input  wire icf_pkg::icf_bus_req_type bus_req,
  output logic [7:0]                    rdata,
  // Interrupt
  output logic                          irq,
  // Pin pair A
  input  wire logic                     pin_a_scl_i,
  input  wire logic                     pin_a_sda_i,
  output icf_pkg::icf_od_pin_type       pin_a_scl,
  output icf_pkg::icf_od_pin_type       pin_a_sda,
  // Pin pair B
  input  wire logic                     pin_b_scl_i,
  input  wire logic                     pin_b_sda_i,
  output icf_pkg::icf_od_pin_type       pin_b_scl,
  output icf_pkg::icf_od_pin_type       pin_b_sda
);
  import icf_pkg::*;

  localparam logic [CNT_W-1:0] CNT_MAX  = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_HOLD = CNT_W'(HOLD_CYC);

  icf_state_type    state_reg, state_next;
  logic             en_reg, sta_reg, sto_reg, si_reg, aa_reg, swap_reg, rx_reg;
  logic [7:0]       status_reg, status_new, data_reg, shift_reg;
  logic [3:0]       bit_reg;
  logic             bytes_done_reg, bus_busy_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [3:0]       sync1_reg, sync2_reg;
  logic             scl_prev_reg, sda_prev_reg, scl_drv_reg, sda_drv_reg;
  logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
  logic             scl_s, sda_s, start_det, stop_det, tick, count_en;
  logic             status_load, recover, bus_err_ev, scl_want, sda_want;
  logic             wr_ctl, wr_data, wr_mode, wr_istat, wr_imask;

  assign wr_ctl   = bus_req.wr && (bus_req.addr == ADDR_CONTROL);
  assign wr_data  = bus_req.wr && (bus_req.addr == ADDR_DATA);
  assign wr_mode  = bus_req.wr && (bus_req.addr == ADDR_MODE);
  assign wr_istat = bus_req.wr && (bus_req.addr == ADDR_IRQ_STAT);
  assign wr_imask = bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK);

  // Pin synchronisers; only the second stage is read by logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end else if (ce) begin
      sync1_reg <= {pin_b_sda_i, pin_b_scl_i, pin_a_sda_i, pin_a_scl_i};
      sync2_reg <= sync1_reg;
    end
  end

  // Input pair follows the swap select directly
  assign scl_s = swap_reg ? sync2_reg[PIN_B_SCL] : sync2_reg[PIN_A_SCL];
  assign sda_s = swap_reg ? sync2_reg[PIN_B_SDA] : sync2_reg[PIN_A_SDA];

  // Bus condition detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (ce) begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_det  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_busy_reg <= 1'b0;
    end else if (ce) begin
      if (!en_reg || stop_det) begin
        bus_busy_reg <= 1'b0;
      end else if (start_det) begin
        bus_busy_reg <= 1'b1;
      end
    end
  end

  // Half-period counter; in released-clock states it waits for the line to rise,
  // which lets a slow slave stretch the clock
  assign count_en = scl_want ? 1'b1 : scl_s;
  assign tick     = (cnt_reg == CNT_MAX);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (state_next != state_reg) begin
        cnt_reg <= '0;
      end else if (count_en && !tick) begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

  // Sequencer
  always_comb begin
    state_next  = state_reg;
    status_load = 1'b0;
    status_new  = status_reg;
    recover     = 1'b0;
    bus_err_ev  = 1'b0;
    if (!en_reg) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (sta_reg && !si_reg) begin
            state_next = bus_busy_reg ? ST_WAIT_FREE : ST_START_A;
          end
        end
        ST_WAIT_FREE: begin
          if (!sta_reg) begin
            state_next = ST_IDLE;
          end else if (!bus_busy_reg) begin
            state_next = ST_START_A;
          end
        end
        ST_START_A: if (tick) state_next = ST_START_B;
        ST_START_B: begin
          if (tick) begin
            state_next  = ST_HOLD;
            status_load = 1'b1;
            status_new  = bytes_done_reg ? STAT_RSTART : STAT_START;
          end
        end
        ST_HOLD: begin
          if (status_reg == STAT_ERR) begin
            if (sto_reg) begin
              state_next = ST_IDLE;
              recover    = 1'b1;
            end
          end else if (!si_reg) begin
            if (sto_reg) begin
              state_next = ST_STOP_A;
            end else if (sta_reg && bytes_done_reg) begin
              state_next = ST_RSTART_A;
            end else begin
              state_next = ST_BIT_LO;
            end
          end
        end
        ST_BIT_LO, ST_BIT_HI: begin
          if (start_det || stop_det) begin
            state_next  = ST_HOLD;
            status_load = 1'b1;
            status_new  = STAT_ERR;
            bus_err_ev  = 1'b1;
          end else if (tick && state_reg == ST_BIT_LO) begin
            state_next = ST_BIT_HI;
          end else if (tick && bit_reg != BIT_ACK) begin
            state_next = ST_BIT_LO;
          end else if (tick) begin
            state_next  = ST_HOLD;
            status_load = 1'b1;
            if (rx_reg) begin
              status_new = aa_reg ? STAT_RX_ACK : STAT_RX_NACK;
            end else begin
              status_new = sda_s ? STAT_TX_NACK : STAT_TX_ACK;
            end
          end
        end
        ST_STOP_A:   if (tick) state_next = ST_STOP_B;
        ST_STOP_B:   if (tick) state_next = ST_STOP_C;
        ST_STOP_C:   if (tick) state_next = sta_reg ? ST_START_A : ST_IDLE;
        ST_RSTART_A: if (tick) state_next = ST_RSTART_B;
        ST_RSTART_B: if (tick) state_next = ST_START_A;
        default:     state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Status code; new codes are never the idle code
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_reg <= STAT_IDLE;
    end else if (ce) begin
      if (recover) begin
        status_reg <= STAT_IDLE;
      end else if (status_load) begin
        status_reg <= status_new;
      end
    end
  end

  // Bit counter, shifter and byte history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_reg        <= 4'h0;
      shift_reg      <= RESET_BYTE;
      bytes_done_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_HOLD && state_next == ST_BIT_LO) begin
        bit_reg   <= 4'h0;
        shift_reg <= data_reg;
      end else if (state_reg == ST_BIT_HI && state_next == ST_BIT_LO) begin
        bit_reg   <= bit_reg + 4'h1;
        shift_reg <= {shift_reg[6:0], sda_s};
      end
      if (state_reg == ST_BIT_HI && status_load && status_new != STAT_ERR) begin
        bytes_done_reg <= 1'b1;
      end else if (state_reg == ST_START_B && tick) begin
        bytes_done_reg <= 1'b0;
      end else if (state_next == ST_IDLE || state_reg == ST_STOP_C) begin
        // A STOP ends the transfer, so a START right after it is not a repeated one
        bytes_done_reg <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_reg   <= RESET_BYTE[CTL_EN_BIT];
      sta_reg  <= RESET_BYTE[CTL_STA_BIT];
      sto_reg  <= RESET_BYTE[CTL_STO_BIT];
      aa_reg   <= RESET_BYTE[CTL_AA_BIT];
      swap_reg <= RESET_BYTE[CTL_SWAP_BIT];
    end else if (ce) begin
      if (stop_det || recover) begin
        sto_reg <= 1'b0;
      end
      if (wr_ctl) begin
        en_reg   <= bus_req.wdata[CTL_EN_BIT];
        sta_reg  <= bus_req.wdata[CTL_STA_BIT];
        sto_reg  <= bus_req.wdata[CTL_STO_BIT];
        aa_reg   <= bus_req.wdata[CTL_AA_BIT];
        swap_reg <= bus_req.wdata[CTL_SWAP_BIT];
      end
    end
  end

  // Event flag: hardware sets, software clears by writing zero; a set beats a clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      si_reg <= 1'b0;
    end else if (ce) begin
      if (status_load) begin
        si_reg <= 1'b1;
      end else if (recover) begin
        si_reg <= 1'b0;
      end else if (wr_ctl && !bus_req.wdata[CTL_SI_BIT]) begin
        si_reg <= 1'b0;
      end
    end
  end

  // Data and mode registers; a received byte overwrites the data register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_reg <= RESET_BYTE;
      rx_reg   <= RESET_BYTE[MODE_RX_BIT];
    end else if (ce) begin
      if (rx_reg && state_reg == ST_BIT_HI && status_load && status_new != STAT_ERR) begin
        data_reg <= shift_reg;
      end else if (wr_data) begin
        data_reg <= bus_req.wdata;
      end
      if (wr_mode) begin
        rx_reg <= bus_req.wdata[MODE_RX_BIT];
      end
    end
  end

  // Wanted line levels, 1 pulls the line low
  always_comb begin
    scl_want = 1'b0;
    sda_want = 1'b0;
    case (state_reg)
      ST_START_A:  sda_want = 1'b1;
      ST_START_B: begin
        scl_want = 1'b1;
        sda_want = 1'b1;
      end
      ST_HOLD:     scl_want = (status_reg != STAT_ERR);
      ST_BIT_LO, ST_BIT_HI: begin
        scl_want = (state_reg == ST_BIT_LO);
        if (bit_reg == BIT_ACK) begin
          sda_want = rx_reg && aa_reg;
        end else begin
          sda_want = !rx_reg && !shift_reg[7];
        end
      end
      ST_STOP_A: begin
        scl_want = 1'b1;
        sda_want = 1'b1;
      end
      ST_STOP_B:   sda_want = 1'b1;
      ST_RSTART_A: scl_want = 1'b1;
      default: begin
        scl_want = 1'b0;
        sda_want = 1'b0;
      end
    endcase
  end

  // Data is held for a short time after the clock falls, so that a data change
  // never races the falling clock and looks like a START or STOP
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else if (ce) begin
      scl_drv_reg <= scl_want;
      if (!(scl_want && cnt_reg < CNT_HOLD && state_reg != ST_START_B)) begin
        sda_drv_reg <= sda_want;
      end
    end
  end

  // Pin outputs; the unused pair stays released
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_a_scl <= '{o: 1'b0, oe_n: 1'b1};
      pin_a_sda <= '{o: 1'b0, oe_n: 1'b1};
      pin_b_scl <= '{o: 1'b0, oe_n: 1'b1};
      pin_b_sda <= '{o: 1'b0, oe_n: 1'b1};
    end else if (ce) begin
      pin_a_scl.oe_n <= swap_reg || !scl_drv_reg;
      pin_a_sda.oe_n <= swap_reg || !sda_drv_reg;
      pin_b_scl.oe_n <= !swap_reg || !scl_drv_reg;
      pin_b_sda.oe_n <= !swap_reg || !sda_drv_reg;
    end
  end

  // Interrupt status, mask and output
  assign irq_ev = {bus_err_ev, stop_det, status_load};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq          <= 1'b0;
    end else if (ce) begin
      irq_stat_reg <= irq_ev | (irq_stat_reg & ~(wr_istat ? bus_req.wdata[IRQ_W-1:0] : '0));
      if (wr_imask) begin
        irq_mask_reg <= bus_req.wdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= RESET_BYTE;
    end else if (ce) begin
      rdata <= RESET_BYTE;
      if (bus_req.rd) begin
        case (bus_req.addr)
          ADDR_CONTROL:  rdata <= {1'b0, en_reg, sta_reg, sto_reg, si_reg, aa_reg, 1'b0, swap_reg};
          ADDR_STATUS:   rdata <= {status_reg[7:3], 3'b000};
          ADDR_DATA:     rdata <= data_reg;
          ADDR_MODE:     rdata <= {7'h00, rx_reg};
          ADDR_IRQ_STAT: rdata <= {5'h00, irq_stat_reg};
          ADDR_IRQ_MASK: rdata <= {5'h00, irq_mask_reg};
          default:       rdata <= RESET_BYTE;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_hold_resume;
    ce && en_reg && state_reg == ST_HOLD && !si_reg && status_reg != STAT_ERR && !sto_reg;
  endsequence

  sequence s_ack_slot_rx;
    ce && en_reg && state_reg == ST_BIT_LO && bit_reg == BIT_ACK && rx_reg && cnt_reg >= CNT_HOLD;
  endsequence

  a_start_when_free: assert property (ce && en_reg && state_reg == ST_IDLE && sta_reg && !si_reg && !bus_busy_reg
    |=> state_reg == ST_START_A) else $error("start not begun on free bus");
  a_wait_when_busy: assert property (ce && en_reg && state_reg == ST_IDLE && sta_reg && !si_reg && bus_busy_reg
    |=> state_reg == ST_WAIT_FREE) else $error("busy bus not waited for");
  a_repeat_start: assert property (s_hold_resume and (sta_reg && bytes_done_reg)
    |=> state_reg == ST_RSTART_A) else $error("repeated start missing");
  a_begin_kept: assert property (ce && sta_reg && !wr_ctl |=> sta_reg) else $error("begin flag cleared by hardware");
  a_stop_sent: assert property (ce && en_reg && state_reg == ST_HOLD && !si_reg && status_reg != STAT_ERR && sto_reg
    |=> state_reg == ST_STOP_A) else $error("stop not sent");
  a_stop_clears: assert property (ce && stop_det && !wr_ctl |=> !sto_reg) else $error("terminate flag kept");
  a_error_recover: assert property (ce && en_reg && state_reg == ST_HOLD && status_reg == STAT_ERR && sto_reg
    |=> state_reg == ST_IDLE && status_reg == STAT_IDLE ##1 !sda_drv_reg) else $error("bad recovery");
  a_stop_then_go: assert property (ce && en_reg && state_reg == ST_STOP_C && tick && sta_reg
    |=> state_reg == ST_START_A) else $error("start does not follow stop");
  a_flag_on_entry: assert property (ce && status_load |=> si_reg && status_reg != STAT_IDLE) else $error("flag not set");
  a_clock_held: assert property (si_reg && state_reg == ST_HOLD && status_reg != STAT_ERR && ce
    |=> scl_drv_reg) else $error("clock not held low");
  a_resume_byte: assert property (s_hold_resume and !(sta_reg && bytes_done_reg)
    |=> state_reg == ST_BIT_LO) else $error("transfer not resumed");
  a_ack_level: assert property (s_ack_slot_rx |=> sda_drv_reg == $past(aa_reg)) else $error("wrong ack level");
  a_idle_flag_low: assert property (status_reg == STAT_IDLE |-> !si_reg) else $error("flag set in idle");
  a_swap_route: assert property (ce && swap_reg |=> pin_a_scl.oe_n && pin_a_sda.oe_n
    && pin_b_scl.oe_n == !$past(scl_drv_reg)) else $error("pins not routed");

endmodule

// ===== src/icf_pkg.sv
// Shared constants and types for the I2C control-flag block
package icf_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned SCL_HALF_NS    = 1250;
  localparam int unsigned SCL_HALF_CYC   = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_HOLD_NS   = 200;
  localparam int unsigned DATA_HOLD_CYC  = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 12;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS   = 8'hBD;
  localparam logic [7:0] ADDR_CONTROL  = 8'hC0;
  localparam logic [7:0] ADDR_DATA     = 8'hC1;
  localparam logic [7:0] ADDR_MODE     = 8'hC2;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hC3;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hC4;

  // Control register fields
  localparam int CTL_EN_BIT   = 6;
  localparam int CTL_STA_BIT  = 5;
  localparam int CTL_STO_BIT  = 4;
  localparam int CTL_SI_BIT   = 3;
  localparam int CTL_AA_BIT   = 2;
  localparam int CTL_SWAP_BIT = 0;
  localparam int MODE_RX_BIT  = 0;

  // Interrupt status and mask fields
  localparam int IRQ_W        = 3;
  localparam int IRQ_SI_BIT   = 0;
  localparam int IRQ_STOP_BIT = 1;
  localparam int IRQ_ERR_BIT  = 2;

  // Synchroniser lanes for the two pin pairs
  localparam int PIN_A_SCL = 0;
  localparam int PIN_A_SDA = 1;
  localparam int PIN_B_SCL = 2;
  localparam int PIN_B_SDA = 3;

  // Reset values and bit index of the acknowledge slot
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] BIT_ACK    = 4'h8;

  // Status codes
  localparam logic [7:0] STAT_IDLE    = 8'hF8;
  localparam logic [7:0] STAT_ERR     = 8'h00;
  localparam logic [7:0] STAT_START   = 8'h08;
  localparam logic [7:0] STAT_RSTART  = 8'h10;
  localparam logic [7:0] STAT_TX_ACK  = 8'h28;
  localparam logic [7:0] STAT_TX_NACK = 8'h30;
  localparam logic [7:0] STAT_RX_ACK  = 8'h50;
  localparam logic [7:0] STAT_RX_NACK = 8'h58;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_FREE, ST_START_A, ST_START_B, ST_HOLD, ST_BIT_LO, ST_BIT_HI,
    ST_STOP_A, ST_STOP_B, ST_STOP_C, ST_RSTART_A, ST_RSTART_B
  } icf_state_type;

  typedef struct packed {
    logic       o;
    logic       oe_n;
  } icf_od_pin_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } icf_bus_req_type;

endpackage

// ===== verification/icf_slave_model.sv
// Bus slave model: frames bytes, records them MSB first and acknowledges on request
`timescale 1ns/1ps
module icf_slave_model (
  // Clock
  input  wire logic       mclk,
  // Resolved wire levels and acknowledge choice
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_on,
  // Pull-down of SDA and last byte seen
  output logic            sda_low,
  output logic [7:0]      rx_byte
);
  logic       scl_d   = 1'b1;
  logic       sda_d   = 1'b1;
  logic [3:0] bit_cnt = 4'h0;
  initial sda_low = 1'b0;
  initial rx_byte = 8'h00;
  always @(posedge mclk) begin
    scl_d <= scl;
    sda_d <= sda;
    if (scl && scl_d && (sda != sda_d)) begin
      // START or STOP restarts the framing
      bit_cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (scl && !scl_d) begin
      if (bit_cnt < 4'h8) rx_byte <= {rx_byte[6:0], sda};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (!scl && scl_d) begin
      // Pull only while SCL is low so no false START or STOP appears
      sda_low <= (bit_cnt == 4'h8) && ack_on;
      if (bit_cnt == 4'h9) bit_cnt <= 4'h0;
    end
  end
endmodule

// ===== verification/i2c_control_flags_tb.sv
// Testbench for the I2C control-flag block
`timescale 1ns/1ps
module i2c_control_flags_tb;
  import icf_pkg::*;
  logic            mclk;
  logic            rst;
  logic            ce;
  icf_bus_req_type req;
  logic [7:0]      rdata;
  logic            irq;
  icf_od_pin_type  a_scl, a_sda, b_scl, b_sda;
  logic            tb_sda_low;
  logic            ack_on;
  logic            s_low;
  logic [7:0]      rx_byte;
  int              fails;
  int              checks_done;
  int              n;
  // Open-drain wires with pull-ups
  wire scl_w = a_scl.oe_n;
  wire sda_w = a_sda.oe_n & ~tb_sda_low & ~s_low;

  icf_top #(.HALF_CYC(4), .HOLD_CYC(2)) u_icf_top (
    .mclk(mclk), .rst(rst), .ce(ce), .bus_req(req), .rdata(rdata), .irq(irq),
    .pin_a_scl_i(scl_w), .pin_a_sda_i(sda_w), .pin_a_scl(a_scl), .pin_a_sda(a_sda),
    .pin_b_scl_i(b_scl.oe_n), .pin_b_sda_i(b_sda.oe_n), .pin_b_scl(b_scl), .pin_b_sda(b_sda));
  icf_slave_model u_icf_slave_model (
    .mclk(mclk), .scl(scl_w), .sda(sda_w), .ack_on(ack_on), .sda_low(s_low), .rx_byte(rx_byte));

  task automatic close_out();
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    @(negedge mclk);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    cmp(d & m, e);
  endtask
  // Poll the control register until the masked bits match, bounded
  task automatic wait_ctl(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    int k;
    for (k = 0; k < 3000; k++) begin
      rd(ADDR_CONTROL, d);
      if ((d & m) === e) break;
    end
    if (k == 3000) begin
      fails++;
      close_out();
    end
  endtask
  // Wait for the clock wire to reach a level, bounded; sampled off the clock edge
  task automatic wait_scl(input logic lvl);
    int k;
    for (k = 0; k < 200 && scl_w !== lvl; k++) @(negedge mclk);
    if (k == 200) begin
      fails++;
      close_out();
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1; ce = 1'b1; req = '0; tb_sda_low = 1'b0; ack_on = 1'b1;
    fails = 0; checks_done = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    chk(ADDR_CONTROL, 8'hFF, 8'h00);
    chk(ADDR_STATUS, 8'hFF, STAT_IDLE);
    chk(8'h55, 8'hFF, 8'h00);
    wr(ADDR_CONTROL, 8'h86);
    chk(ADDR_CONTROL, 8'hFF, 8'h04);
    // Swapped pair first; lines idle high before enabling
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_CONTROL, 8'h61);
    wait_ctl(8'h08, 8'h08);
    cmp({4'h0, b_scl.oe_n, b_sda.oe_n, a_scl.oe_n, a_sda.oe_n}, 8'h03);
    chk(ADDR_STATUS, 8'hFF, STAT_START);
    cmp(8'(irq), 8'h01);
    wr(ADDR_IRQ_STAT, 8'h01);
    chk(ADDR_IRQ_STAT, 8'h01, 8'h00);
    cmp(8'(irq), 8'h00);
    wr(ADDR_CONTROL, 8'h51);
    wait_ctl(8'h10, 8'h00);
    cmp({6'h0, b_scl.oe_n, b_sda.oe_n}, 8'h03);
    chk(ADDR_IRQ_STAT, 8'h02, 8'h02);
    // Normal pair with the slave model
    wr(ADDR_CONTROL, 8'h60);
    wait_ctl(8'h08, 8'h08);
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    cmp(8'(scl_w), 8'h00);
    for (n = 0; n < 2; n++) begin
      ack_on <= (n == 0);
      wr(ADDR_DATA, n == 0 ? 8'hA5 : 8'h3C);
      wr(ADDR_CONTROL, 8'h44);
      wait_ctl(8'h08, 8'h08);
      chk(ADDR_STATUS, 8'hFF, n == 0 ? STAT_TX_ACK : STAT_TX_NACK);
      cmp(rx_byte, n == 0 ? 8'hA5 : 8'h3C);
    end
    wr(ADDR_CONTROL, 8'h64);
    wait_ctl(8'h08, 8'h08);
    chk(ADDR_STATUS, 8'hFF, STAT_RSTART);
    chk(ADDR_CONTROL, 8'h20, 8'h20);
    // Receive with and without own acknowledge
    ack_on <= 1'b0;
    wr(ADDR_MODE, 8'h01);
    for (n = 0; n < 2; n++) begin
      wr(ADDR_CONTROL, n == 0 ? 8'h44 : 8'h40);
      wait_ctl(8'h08, 8'h08);
      chk(ADDR_STATUS, 8'hFF, n == 0 ? STAT_RX_ACK : STAT_RX_NACK);
      chk(ADDR_DATA, 8'hFF, 8'hFF);
    end
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h74);
    wait_ctl(8'h08, 8'h08);
    chk(ADDR_STATUS, 8'hFF, STAT_START);
    chk(ADDR_CONTROL, 8'h10, 8'h00);
    wr(ADDR_CONTROL, 8'h54);
    wait_ctl(8'h10, 8'h00);
    // Another master holds the bus; masked event keeps irq low
    wr(ADDR_IRQ_MASK, 8'h00);
    tb_sda_low <= 1'b1;
    // The foreign START must pass the synchroniser before the request lands
    repeat (4) @(posedge mclk);
    wr(ADDR_CONTROL, 8'h60);
    repeat (30) @(posedge mclk);
    @(negedge mclk);
    cmp(8'(a_sda.oe_n), 8'h01);
    tb_sda_low <= 1'b0;
    wait_ctl(8'h08, 8'h08);
    chk(ADDR_STATUS, 8'hFF, STAT_START);
    cmp(8'(irq), 8'h00);
    // START forced in mid-byte gives bus error, then recovery
    ack_on <= 1'b1;
    wr(ADDR_DATA, 8'hFF);
    wr(ADDR_CONTROL, 8'h44);
    wait_scl(1'b0);
    wait_scl(1'b1);
    // Let the synchronised clock read high first, else the data edge is missed
    @(posedge mclk);
    tb_sda_low <= 1'b1;
    wait_ctl(8'h08, 8'h08);
    chk(ADDR_STATUS, 8'hFF, STAT_ERR);
    chk(ADDR_IRQ_STAT, 8'h04, 8'h04);
    tb_sda_low <= 1'b0;
    wr(ADDR_CONTROL, 8'h54);
    chk(ADDR_STATUS, 8'hFF, STAT_IDLE);
    chk(ADDR_CONTROL, 8'h18, 8'h00);
    cmp({6'h0, a_scl.oe_n, a_sda.oe_n}, 8'h03);
    cmp({6'h0, a_scl.o, b_sda.o}, 8'h00);
    // A write while the clock enable is low must not land
    ce <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    ce <= 1'b1;
    chk(ADDR_CONTROL, 8'hFF, 8'h44);
    close_out();
  end
endmodule
